// >>> shared/ars_pkg.sv
// Constants, register map and state encoding of the auto-reclose sequencer.
// Assumes a 250 MHz system clock and a word-aligned Avalon-MM register bus.
package ars_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned TICK_PERIOD_NS = 1000000;
   localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] SHOT_OFS = 8'h04;
   localparam logic [7:0] DEAD_OFS = 8'h08;
   localparam logic [7:0] RECLAIM_OFS = 8'h0C;
   localparam logic [7:0] ARC_OFS = 8'h10;
   localparam logic [7:0] DISCR_OFS = 8'h14;
   localparam logic [7:0] GEN_OFS = 8'h18;
   localparam logic [7:0] EVMASK_OFS = 8'h1C;
   localparam logic [7:0] STATUS_OFS = 8'h20;
   localparam logic [7:0] CNTCLR_OFS = 8'h24;
   localparam logic [7:0] STAMP_OFS = 8'h28;
   localparam logic [7:0] CNT_BASE_OFS = 8'h40;
   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_SEL_BIT = 1;
   localparam int unsigned CTRL_OBJ_BIT = 2;
   localparam int unsigned CTRL_GEN_BIT = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [4:0] SHOT_RST = 5'h01;
   localparam logic [15:0] TIME_RST = 16'h0000;
   localparam logic [15:0] EVMASK_RST = 16'hFFFF;
   localparam int unsigned NUM_CNT = 8;
   localparam int unsigned NUM_EVT = 16;
   // Shot option field: arcing and discrimination are exclusive codes
   localparam logic [1:0] OPT_NONE = 2'h0;
   localparam logic [1:0] OPT_ARC = 2'h1;
   localparam logic [1:0] OPT_DISCR = 2'h2;
   typedef enum logic [3:0] {
      ST_DISABLED = 4'h0, ST_READY = 4'h1, ST_OPEN_WAIT = 4'h2, ST_DEAD = 4'h3,
      ST_CLOSE_WAIT = 4'h4, ST_RECLAIM = 4'h5, ST_GEN_RECLAIM = 4'h6,
      ST_FINAL = 4'h7, ST_LOCKED = 4'h8, ST_HALTED = 4'h9
   } ars_state_t;
endpackage

// >>> hw/ars_sequencer.sv
// Auto-reclose sequencer: request arbitration, shot sequencing, breaker
// commands, event stream and counters behind an Avalon-MM slave.
// Assumes all inputs synchronous to REF_CLK and a breaker object block
// that reports position and operation failures.
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module ars_sequencer #(
   parameter int unsigned TICK_CYCLES = ars_pkg::TICK_CYCLES,
   parameter int unsigned MAX_SHOTS = 5
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // Avalon-MM slave
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Reclose requests and controls
   input wire logic RECLOSE_REQUEST_PRIO1,
   input wire logic RECLOSE_REQUEST_PRIO2,
   input wire logic RECLOSE_REQUEST_PRIO3,
   input wire logic RECLOSE_REQUEST_PRIO4,
   input wire logic RECLOSE_REQUEST_PRIO5,
   input wire logic RECLOSER_ENABLE_INPUT,
   input wire logic LOCKOUT_RELEASE_INPUT,
   input wire logic LOCK_INPUT,
   input wire logic CRITICAL_LOCK_REQUEST,
   // Breaker object status
   input wire logic BRK_OPEN_IND,
   input wire logic BRK_CLOSED_IND,
   input wire logic MANUAL_OPEN,
   input wire logic MANUAL_CLOSE,
   input wire logic OBJ_OP_FAIL,
   // Breaker commands and status
   output logic OBJECT_OPEN_CMD,
   output logic OBJECT_CLOSE_CMD,
   output logic FOLLOWER_OPEN_CMD,
   output logic FOLLOWER_CLOSE_PERMIT,
   output logic AR_READY,
   output logic AR_RUNNING,
   output logic AR_LOCKED,
   output logic AR_FINAL_TRIP,
   // Event stream
   output logic EVT_VALID,
   output logic [15:0] EVT_CHANGED,
   output logic [15:0] EVT_LEVELS,
   output logic [31:0] EVT_STAMP
);
   // ****************************************
   // Registers
   // ****************************************
   ars_pkg::ars_state_t state_q, state_d;
   logic [3:0] ctrl_q;
   logic [4:0] shot_cfg_q;
   logic [15:0] dead_q, reclaim_q, arc_lim_q, discr_q, gen_q, evmask_q;
   logic [2:0] shot_q, shot_d;
   logic [4:0] win_q, win_d;
   logic [15:0] tmr_q, arc_q;
   logic lock_after_q, lock_after_d;
   logic permit_q, permit_d;
   logic final_q;
   logic [31:0] tick_cnt_q;
   logic tick;
   logic [31:0] stamp_q;
   logic ack_q;
   logic [4:0] req, req_q, win;
   logic req_any, enabled, running, advance_ok;
   logic [15:0] cnt_q [ars_pkg::NUM_CNT];
   logic [ars_pkg::NUM_CNT-1:0] cnt_inc, cnt_clr;
   logic [15:0] evt_src, evt_prev_q;
   logic [1:0] opt;
   logic [2:0] num_shots;

   assign req = {RECLOSE_REQUEST_PRIO5, RECLOSE_REQUEST_PRIO4, RECLOSE_REQUEST_PRIO3,
                 RECLOSE_REQUEST_PRIO2, RECLOSE_REQUEST_PRIO1};
   assign req_any = |req;
   assign opt = shot_cfg_q[4:3];
   assign num_shots = (shot_cfg_q[2:0] > 3'(MAX_SHOTS)) ? 3'(MAX_SHOTS) : shot_cfg_q[2:0];
   // Object must be configured before anything runs
   assign enabled = ctrl_q[ars_pkg::CTRL_OBJ_BIT] & ctrl_q[ars_pkg::CTRL_EN_BIT]
                    & (~ctrl_q[ars_pkg::CTRL_SEL_BIT] | RECLOSER_ENABLE_INPUT);
   assign running = (state_q == ars_pkg::ST_OPEN_WAIT) || (state_q == ars_pkg::ST_DEAD)
                    || (state_q == ars_pkg::ST_CLOSE_WAIT) || (state_q == ars_pkg::ST_RECLAIM);
   assign advance_ok = shot_q < num_shots;

   // Fixed priority, lowest index wins
   always_comb begin
      win = 5'h00;
      if (req[0]) win = 5'h01;
      else if (req[1]) win = 5'h02;
      else if (req[2]) win = 5'h04;
      else if (req[3]) win = 5'h08;
      else if (req[4]) win = 5'h10;
   end

   // ****************************************
   // Millisecond tick and time stamp
   // ****************************************
   assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) tick_cnt_q <= 32'h0;
      else tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
   end
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) stamp_q <= 32'h0;
      else if (tick) stamp_q <= stamp_q + 32'h1;
   end

   // ****************************************
   // Sequence state machine
   // ****************************************
   // Settings are read live, so a mid-sequence change applies at once
   always_comb begin
      state_d = state_q;
      shot_d = shot_q;
      win_d = win_q;
      lock_after_d = lock_after_q;
      permit_d = permit_q;
      case (state_q)
         ars_pkg::ST_DISABLED: begin
            state_d = ars_pkg::ST_READY;
         end
         ars_pkg::ST_READY: begin
            if (tick && req_any && num_shots != 3'h0) begin
               state_d = ars_pkg::ST_OPEN_WAIT;
               shot_d = 3'h1;
               win_d = win;
               lock_after_d = 1'b0;
               permit_d = 1'b0;
            end
         end
         ars_pkg::ST_OPEN_WAIT: begin
            if (BRK_OPEN_IND) state_d = ars_pkg::ST_DEAD;
         end
         ars_pkg::ST_DEAD: begin
            if (MANUAL_CLOSE) begin
               state_d = ars_pkg::ST_GEN_RECLAIM;
               lock_after_d = 1'b1;
            end else if (tmr_q >= dead_q) state_d = ars_pkg::ST_CLOSE_WAIT;
         end
         ars_pkg::ST_CLOSE_WAIT: begin
            if (BRK_CLOSED_IND) state_d = ars_pkg::ST_RECLAIM;
         end
         ars_pkg::ST_RECLAIM: begin
            if (opt == ars_pkg::OPT_DISCR && tmr_q < discr_q && tick && req_any) begin
               state_d = ars_pkg::ST_HALTED;
            end else if (tick && req_any && (opt != ars_pkg::OPT_ARC
                         || arc_q + 16'h1 >= arc_lim_q)) begin
               if (advance_ok) begin
                  state_d = ars_pkg::ST_OPEN_WAIT;
                  shot_d = shot_q + 3'h1;
               end else state_d = ars_pkg::ST_FINAL;
            end else if (tmr_q >= reclaim_q) begin
               permit_d = 1'b1;
               state_d = (ctrl_q[ars_pkg::CTRL_GEN_BIT] && gen_q != 16'h0) ? ars_pkg::ST_GEN_RECLAIM
                         : ars_pkg::ST_READY;
            end
         end
         ars_pkg::ST_GEN_RECLAIM: begin
            // Fault returning soon after success goes straight to final trip
            if (tick && req_any && !lock_after_q) state_d = ars_pkg::ST_FINAL;
            else if (tmr_q >= gen_q) state_d = lock_after_q ? ars_pkg::ST_LOCKED : ars_pkg::ST_READY;
         end
         ars_pkg::ST_FINAL: begin
            if (BRK_OPEN_IND) state_d = ars_pkg::ST_LOCKED;
         end
         ars_pkg::ST_LOCKED: begin
            if (LOCKOUT_RELEASE_INPUT && !LOCK_INPUT) state_d = ars_pkg::ST_READY;
         end
         ars_pkg::ST_HALTED: begin
            if (LOCKOUT_RELEASE_INPUT && BRK_CLOSED_IND) state_d = ars_pkg::ST_READY;
         end
         default: state_d = ars_pkg::ST_DISABLED;
      endcase
      // Overrides, lowest priority first
      if (running && state_q != ars_pkg::ST_DEAD && (MANUAL_OPEN || MANUAL_CLOSE))
         state_d = ars_pkg::ST_READY;
      if (state_q == ars_pkg::ST_DEAD && MANUAL_OPEN) state_d = ars_pkg::ST_READY;
      if (running && OBJ_OP_FAIL) state_d = ars_pkg::ST_LOCKED;
      if (state_q != ars_pkg::ST_HALTED && LOCK_INPUT) state_d = ars_pkg::ST_LOCKED;
      if (CRITICAL_LOCK_REQUEST) state_d = ars_pkg::ST_LOCKED;
      if (!enabled) state_d = ars_pkg::ST_DISABLED;
      if (state_d == ars_pkg::ST_READY || state_d == ars_pkg::ST_LOCKED
          || state_d == ars_pkg::ST_DISABLED || state_d == ars_pkg::ST_HALTED) begin
         shot_d = 3'h0;
         win_d = 5'h00;
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         state_q <= ars_pkg::ST_DISABLED;
         shot_q <= 3'h0;
         win_q <= 5'h00;
         lock_after_q <= 1'b0;
         permit_q <= 1'b0;
      end else begin
         state_q <= state_d;
         shot_q <= shot_d;
         win_q <= win_d;
         lock_after_q <= lock_after_d;
         permit_q <= permit_d;
      end
   end

   // One timer serves dead, reclaim and discrimination; the latter two share a start
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) tmr_q <= 16'h0;
      else if (state_d != state_q) tmr_q <= 16'h0;
      else if (tick && tmr_q != 16'hFFFF) tmr_q <= tmr_q + 16'h1;
   end

   // Arcing time survives reclaim pauses and clears whenever the shot number changes, including its return to zero
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) arc_q <= 16'h0;
      else if (shot_d != shot_q) arc_q <= 16'h0;
      else if (state_q == ars_pkg::ST_RECLAIM && opt == ars_pkg::OPT_ARC && tick && req_any)
         arc_q <= arc_q + 16'h1;
   end

   // ****************************************
   // Commands and indications
   // ****************************************
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         OBJECT_OPEN_CMD <= 1'b0;
         OBJECT_CLOSE_CMD <= 1'b0;
         FOLLOWER_OPEN_CMD <= 1'b0;
         AR_READY <= 1'b0;
         AR_RUNNING <= 1'b0;
         AR_LOCKED <= 1'b0;
         final_q <= 1'b0;
      end else begin
         OBJECT_OPEN_CMD <= (state_d == ars_pkg::ST_OPEN_WAIT) || (state_d == ars_pkg::ST_FINAL);
         OBJECT_CLOSE_CMD <= (state_d == ars_pkg::ST_CLOSE_WAIT);
         FOLLOWER_OPEN_CMD <= (state_d == ars_pkg::ST_OPEN_WAIT) || (state_d == ars_pkg::ST_DEAD)
                              || (state_d == ars_pkg::ST_CLOSE_WAIT)
                              || (state_d == ars_pkg::ST_RECLAIM);
         AR_READY <= (state_d == ars_pkg::ST_READY);
         AR_RUNNING <= (state_d == ars_pkg::ST_OPEN_WAIT) || (state_d == ars_pkg::ST_DEAD)
                       || (state_d == ars_pkg::ST_CLOSE_WAIT) || (state_d == ars_pkg::ST_RECLAIM);
         AR_LOCKED <= (state_d == ars_pkg::ST_LOCKED) || (state_d == ars_pkg::ST_HALTED);
         if (state_d == ars_pkg::ST_FINAL) final_q <= 1'b1;
         else if (state_d == ars_pkg::ST_READY || state_d == ars_pkg::ST_DISABLED) final_q <= 1'b0;
      end
   end
   assign AR_FINAL_TRIP = final_q;
   assign FOLLOWER_CLOSE_PERMIT = permit_q;

   // ****************************************
   // Events
   // ****************************************
   assign evt_src = {OBJECT_OPEN_CMD, OBJECT_CLOSE_CMD, AR_RUNNING, AR_LOCKED, final_q,
                     req, RECLOSER_ENABLE_INPUT, LOCKOUT_RELEASE_INPUT, LOCK_INPUT,
                     CRITICAL_LOCK_REQUEST, BRK_OPEN_IND, BRK_CLOSED_IND};
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         evt_prev_q <= 16'h0;
         EVT_VALID <= 1'b0;
         EVT_CHANGED <= 16'h0;
         EVT_LEVELS <= 16'h0;
         EVT_STAMP <= 32'h0;
      end else begin
         evt_prev_q <= evt_src;
         EVT_VALID <= |((evt_src ^ evt_prev_q) & evmask_q);
         EVT_CHANGED <= (evt_src ^ evt_prev_q) & evmask_q;
         EVT_LEVELS <= evt_src;
         EVT_STAMP <= stamp_q;
      end
   end

   // ****************************************
   // Counters
   // ****************************************
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) req_q <= 5'h00;
      else req_q <= req;
   end
   assign cnt_inc = {state_d == ars_pkg::ST_LOCKED && state_q != ars_pkg::ST_LOCKED,
                     state_d == ars_pkg::ST_FINAL && state_q != ars_pkg::ST_FINAL,
                     state_d == ars_pkg::ST_OPEN_WAIT && shot_d != shot_q,
                     req & ~req_q};
   assign cnt_clr = (AVS_WRITE && ack_q && AVS_ADDRESS == ars_pkg::CNTCLR_OFS)
                    ? AVS_WRITEDATA[ars_pkg::NUM_CNT-1:0] : '0;
   generate
      for (genvar i = 0; i < ars_pkg::NUM_CNT; i++) begin : g_cnt
         // A count landing with its clear is kept
         always_ff @(posedge REF_CLK or negedge NRST) begin
            if (!NRST) cnt_q[i] <= 16'h0;
            else if (cnt_inc[i]) cnt_q[i] <= (cnt_clr[i] ? 16'h0 : cnt_q[i]) + 16'h1;
            else if (cnt_clr[i]) cnt_q[i] <= 16'h0;
         end
      end
   endgenerate

   // ****************************************
   // Avalon-MM slave
   // ****************************************
   // Every access waits exactly one cycle; a fixed latency keeps the master simple
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) ack_q <= 1'b0;
      else ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         ctrl_q <= ars_pkg::CTRL_RST;
         shot_cfg_q <= ars_pkg::SHOT_RST;
         dead_q <= ars_pkg::TIME_RST;
         reclaim_q <= ars_pkg::TIME_RST;
         arc_lim_q <= ars_pkg::TIME_RST;
         discr_q <= ars_pkg::TIME_RST;
         gen_q <= ars_pkg::TIME_RST;
         evmask_q <= ars_pkg::EVMASK_RST;
      end else if (AVS_WRITE && !ack_q) begin
         if (AVS_ADDRESS == ars_pkg::CTRL_OFS) ctrl_q <= AVS_WRITEDATA[3:0];
         else if (AVS_ADDRESS == ars_pkg::SHOT_OFS) begin
            // Code 3 would mean both options; store it as none
            shot_cfg_q <= {(AVS_WRITEDATA[4:3] == 2'h3) ? ars_pkg::OPT_NONE : AVS_WRITEDATA[4:3],
                           AVS_WRITEDATA[2:0]};
         end
         else if (AVS_ADDRESS == ars_pkg::DEAD_OFS) dead_q <= AVS_WRITEDATA[15:0];
         else if (AVS_ADDRESS == ars_pkg::RECLAIM_OFS) reclaim_q <= AVS_WRITEDATA[15:0];
         else if (AVS_ADDRESS == ars_pkg::ARC_OFS) arc_lim_q <= AVS_WRITEDATA[15:0];
         else if (AVS_ADDRESS == ars_pkg::DISCR_OFS) discr_q <= AVS_WRITEDATA[15:0];
         else if (AVS_ADDRESS == ars_pkg::GEN_OFS) gen_q <= AVS_WRITEDATA[15:0];
         else if (AVS_ADDRESS == ars_pkg::EVMASK_OFS) evmask_q <= AVS_WRITEDATA[15:0];
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) AVS_READDATA <= 32'h0;
      else if (AVS_READ && !ack_q) begin
         if (AVS_ADDRESS == ars_pkg::CTRL_OFS) AVS_READDATA <= {28'h0, ctrl_q};
         else if (AVS_ADDRESS == ars_pkg::SHOT_OFS) AVS_READDATA <= {27'h0, shot_cfg_q};
         else if (AVS_ADDRESS == ars_pkg::DEAD_OFS) AVS_READDATA <= {16'h0, dead_q};
         else if (AVS_ADDRESS == ars_pkg::RECLAIM_OFS) AVS_READDATA <= {16'h0, reclaim_q};
         else if (AVS_ADDRESS == ars_pkg::ARC_OFS) AVS_READDATA <= {16'h0, arc_lim_q};
         else if (AVS_ADDRESS == ars_pkg::DISCR_OFS) AVS_READDATA <= {16'h0, discr_q};
         else if (AVS_ADDRESS == ars_pkg::GEN_OFS) AVS_READDATA <= {16'h0, gen_q};
         else if (AVS_ADDRESS == ars_pkg::EVMASK_OFS) AVS_READDATA <= {16'h0, evmask_q};
         else if (AVS_ADDRESS == ars_pkg::STATUS_OFS)
            AVS_READDATA <= {12'h0, arc_q[7:0], win_q, shot_q, state_q};
         else if (AVS_ADDRESS == ars_pkg::STAMP_OFS) AVS_READDATA <= stamp_q;
         else if (AVS_ADDRESS >= ars_pkg::CNT_BASE_OFS
                  && AVS_ADDRESS < ars_pkg::CNT_BASE_OFS + 8'(4 * ars_pkg::NUM_CNT)
                  && AVS_ADDRESS[1:0] == 2'h0)
            AVS_READDATA <= {16'h0, cnt_q[3'(AVS_ADDRESS[4:2])]};
         else AVS_READDATA <= 32'h0;
      end
   end
endmodule

// >>> tb/ars_breaker_model.sv
// Breaker object block model: answers open and close commands with position.
// Assumes commands are levels held until the position indication changes.
`timescale 1ns/100ps
module ars_breaker_model (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Commands from the sequencer
   input wire logic open_cmd,
   input wire logic close_cmd,
   // Position and failure reports
   output logic brk_open,
   output logic brk_closed,
   output logic op_fail
);
   logic [1:0] cnt_q;
   logic open_q;
   // ****************************************
   // Mechanism travel: four cycles, then the position flips
   // ****************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 2'h0;
         open_q <= 1'b0;
      end else if ((open_cmd && !open_q) || (close_cmd && open_q)) begin
         cnt_q <= cnt_q + 2'h1;
         if (cnt_q == 2'h3) begin
            open_q <= open_cmd;
         end
      end else begin
         cnt_q <= 2'h0;
      end
   end
   assign brk_open = open_q;
   assign brk_closed = nrst && !open_q;
   // No scenario commands a failed operation
   assign op_fail = 1'b0;
endmodule

// >>> tb/ars_monitor.sv
// Checker on the sequencer's command and status ports.
// Assumes a bind onto ars_sequencer; a single clock domain.
`timescale 1ns/100ps
module ars_monitor (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // Watched ports
   input wire logic CRITICAL_LOCK_REQUEST,
   input wire logic LOCKOUT_RELEASE_INPUT,
   input wire logic BRK_OPEN_IND,
   input wire logic BRK_CLOSED_IND,
   input wire logic OBJECT_OPEN_CMD,
   input wire logic OBJECT_CLOSE_CMD,
   input wire logic FOLLOWER_OPEN_CMD,
   input wire logic AR_READY,
   input wire logic AR_RUNNING,
   input wire logic AR_LOCKED,
   input wire logic AR_FINAL_TRIP,
   input wire logic EVT_VALID,
   input wire logic [15:0] EVT_CHANGED,
   input wire logic [15:0] EVT_LEVELS
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   a_open_drop: assert property (OBJECT_OPEN_CMD && BRK_OPEN_IND |=> !OBJECT_OPEN_CMD)
      else $error("open command held after open");
   a_close_drop: assert property (OBJECT_CLOSE_CMD && BRK_CLOSED_IND |=> !OBJECT_CLOSE_CMD)
      else $error("close command held after closed");
   a_cmd_excl: assert property (!(OBJECT_OPEN_CMD && OBJECT_CLOSE_CMD))
      else $error("open and close together");
   a_crit_lock: assert property (CRITICAL_LOCK_REQUEST && AR_READY |-> ##[1:8] AR_LOCKED)
      else $error("critical request did not lock");
   a_crit_noshot: assert property (CRITICAL_LOCK_REQUEST && $past(CRITICAL_LOCK_REQUEST) |-> !$rose(OBJECT_OPEN_CMD))
      else $error("shot started under critical");
   a_lock_hold: assert property (AR_LOCKED && !LOCKOUT_RELEASE_INPUT |=> !AR_READY)
      else $error("left lock without release");
   a_ready_excl: assert property (AR_READY |-> !AR_LOCKED && !AR_RUNNING)
      else $error("ready while locked or running");
   a_follower_open: assert property ($rose(OBJECT_OPEN_CMD) && AR_RUNNING && !AR_FINAL_TRIP |-> FOLLOWER_OPEN_CMD)
      else $error("follower not opened");
   a_evt_nonzero: assert property (EVT_VALID |-> EVT_CHANGED != 16'h0000)
      else $error("event with no change");
   a_evt_open: assert property ($rose(OBJECT_OPEN_CMD) |=> EVT_VALID && EVT_CHANGED[15])
      else $error("open command change not logged");
   a_evt_brk: assert property ($rose(BRK_OPEN_IND) |=> EVT_VALID && EVT_CHANGED[1] && EVT_LEVELS[1])
      else $error("breaker open change not logged");
   c_shot: cover property ($rose(OBJECT_OPEN_CMD));
   c_lock: cover property ($rose(AR_LOCKED));
   c_close: cover property ($fell(OBJECT_CLOSE_CMD));
endmodule

// >>> tb/auto_recloser_sequencer_tb_top.sv
// Self-checking bench for the auto-reclose sequencer.
// Assumes the breaker model answers commands; tick shortened to 4 clocks.
`timescale 1ns/100ps
module auto_recloser_sequencer_tb_top;
   logic ref_clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, wait_r, crit = 1'b0, rel = 1'b0, zero = 1'b0;
   logic en_in = 1'b0, lk = 1'b0, mc = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0, rdata, q;
   logic [4:0] req = 5'h00;
   logic bo, bc, fail, oc, cc, fo, perm, rdy, run, lkd, fin;
   int num_errors = 0, samples_checked = 0;
   wire [3:0] stv = {lkd, rdy, cc, oc};
   always #2 ref_clk = ~ref_clk;
   ars_sequencer #(.TICK_CYCLES(4)) ars_sequencer_inst (.REF_CLK(ref_clk), .NRST(nrst), .AVS_ADDRESS(adr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r),
      .RECLOSE_REQUEST_PRIO1(req[0]), .RECLOSE_REQUEST_PRIO2(req[1]), .RECLOSE_REQUEST_PRIO3(req[2]),
      .RECLOSE_REQUEST_PRIO4(req[3]), .RECLOSE_REQUEST_PRIO5(req[4]), .RECLOSER_ENABLE_INPUT(en_in),
      .LOCKOUT_RELEASE_INPUT(rel), .LOCK_INPUT(lk), .CRITICAL_LOCK_REQUEST(crit), .BRK_OPEN_IND(bo),
      .BRK_CLOSED_IND(bc), .MANUAL_OPEN(zero), .MANUAL_CLOSE(mc), .OBJ_OP_FAIL(fail), .OBJECT_OPEN_CMD(oc),
      .OBJECT_CLOSE_CMD(cc), .FOLLOWER_OPEN_CMD(fo), .FOLLOWER_CLOSE_PERMIT(perm), .AR_READY(rdy),
      .AR_RUNNING(run), .AR_LOCKED(lkd), .AR_FINAL_TRIP(fin), .EVT_VALID(), .EVT_CHANGED(), .EVT_LEVELS(),
      .EVT_STAMP());
   ars_breaker_model ars_breaker_model_inst (.clk(ref_clk), .nrst(nrst), .open_cmd(oc), .close_cmd(cc),
      .brk_open(bo), .brk_closed(bc), .op_fail(fail));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      adr <= a; wr <= w; rd <= !w; wd <= d;
      // Only the watchdog ends a stalled access
      do begin
         @(posedge ref_clk);
      end while (wait_r !== 1'b0);
      q = rdata;
      wr <= 1'b0; rd <= 1'b0;
   endtask
   task automatic wt(input logic [3:0] m);
      for (int i = 0; i < 400 && (stv & m) === 4'h0; i++) @(negedge ref_clk);
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      chk(rdy, 1'b0);
      bus(1'b0, 8'h04, 32'h0);
      chk(q, 32'h01);
      bus(1'b0, 8'hFC, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, 8'h00, 32'h1);
      repeat (20) @(negedge ref_clk);
      chk(rdy, 1'b0);
      bus(1'b1, 8'h00, 32'h5); bus(1'b1, 8'h08, 32'h2); bus(1'b1, 8'h0C, 32'h3);
      wt(4'h4); chk(rdy, 1'b1);
      $display("test regs done");
   endtask
   task automatic t_shot(input logic [4:0] r, input logic [7:0] ca, input logic [31:0] shots);
      @(posedge ref_clk) req <= r;
      wt(4'h1); chk({oc, fo, run}, 3'h7);
      bus(1'b0, 8'h20, 32'h0); chk(q[11:7], r & ~(r - 5'h01));
      req <= 5'h00;
      wt(4'h2); chk({cc, bo}, 2'h3);
      wt(4'h4); chk({perm, fin}, 2'h2);
      bus(1'b0, ca, 32'h0); chk(q, 32'h1);
      bus(1'b0, 8'h54, 32'h0); chk(q, shots);
      $display("test shot done");
   endtask
   task automatic t_lock;
      @(posedge ref_clk) crit <= 1'b1;
      wt(4'h8); chk({lkd, oc}, 2'h2);
      @(posedge ref_clk) crit <= 1'b0;
      repeat (20) @(negedge ref_clk);
      chk(rdy, 1'b0);
      @(posedge ref_clk) rel <= 1'b1;
      wt(4'h4); chk(rdy, 1'b1);
      @(posedge ref_clk) rel <= 1'b0;
      $display("test lock done");
   endtask
   task automatic t_lockin;
      @(posedge ref_clk) lk <= 1'b1;
      wt(4'h8);
      chk(lkd, 1'b1);
      @(posedge ref_clk) rel <= 1'b1;
      repeat (20) @(negedge ref_clk);
      chk(rdy, 1'b0);
      @(posedge ref_clk) lk <= 1'b0;
      wt(4'h4);
      chk(rdy, 1'b1);
      @(posedge ref_clk) rel <= 1'b0;
      $display("test lock input done");
   endtask
   task automatic t_enable;
      bus(1'b1, 8'h00, 32'h7);
      repeat (4) @(negedge ref_clk);
      chk(rdy, 1'b0);
      @(posedge ref_clk) en_in <= 1'b1;
      wt(4'h4);
      chk(rdy, 1'b1);
      $display("test enable input done");
   endtask
   task automatic t_discr;
      bus(1'b1, 8'h14, 32'h2);
      bus(1'b1, 8'h04, 32'h11);
      @(posedge ref_clk) req <= 5'h01;
      wt(4'h8);
      chk({lkd, run}, 2'h2);
      @(posedge ref_clk) req <= 5'h00;
      rel <= 1'b1;
      wt(4'h4);
      chk(rdy, 1'b1);
      @(posedge ref_clk) rel <= 1'b0;
      $display("test discrimination done");
   endtask
   task automatic t_arc;
      bus(1'b1, 8'h10, 32'h2);
      bus(1'b1, 8'h04, 32'h0A);
      @(posedge ref_clk) req <= 5'h01;
      wt(4'h8);
      chk({lkd, fin, bo}, 3'h7);
      bus(1'b0, 8'h54, 32'h0);
      req <= 5'h00;
      chk(q, 32'h5);
      bus(1'b0, 8'h58, 32'h0);
      chk(q, 32'h1);
      $display("test arcing done");
   endtask
   task automatic t_manual;
      @(posedge ref_clk) rel <= 1'b1;
      wt(4'h4);
      @(posedge ref_clk) rel <= 1'b0;
      req <= 5'h01;
      wt(4'h1);
      @(posedge ref_clk) mc <= 1'b1;
      req <= 5'h00;
      wt(4'h8);
      chk({lkd, fin}, 2'h2);
      @(posedge ref_clk) mc <= 1'b0;
      $display("test manual close done");
   endtask
   task automatic t_clr;
      bus(1'b1, 8'h24, 32'h1); bus(1'b0, 8'h40, 32'h0); chk(q, 32'h0);
      bus(1'b0, 8'h44, 32'h0); chk(q, 32'h1);
      $display("test clear done");
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      t_regs();
      t_shot(5'h01, 8'h40, 32'h1);
      t_shot(5'h12, 8'h44, 32'h2);
      t_lock();
      t_clr();
      t_lockin();
      t_enable();
      t_discr();
      t_arc();
      t_manual();
      final_report();
   end
   initial begin
      #100000;
      num_errors++;
      final_report();
   end
endmodule
bind ars_sequencer ars_monitor ars_monitor_inst (.REF_CLK(REF_CLK), .NRST(NRST),
   .CRITICAL_LOCK_REQUEST(CRITICAL_LOCK_REQUEST), .LOCKOUT_RELEASE_INPUT(LOCKOUT_RELEASE_INPUT),
   .BRK_OPEN_IND(BRK_OPEN_IND), .BRK_CLOSED_IND(BRK_CLOSED_IND), .OBJECT_OPEN_CMD(OBJECT_OPEN_CMD),
   .OBJECT_CLOSE_CMD(OBJECT_CLOSE_CMD), .FOLLOWER_OPEN_CMD(FOLLOWER_OPEN_CMD), .AR_READY(AR_READY),
   .AR_RUNNING(AR_RUNNING), .AR_LOCKED(AR_LOCKED), .AR_FINAL_TRIP(AR_FINAL_TRIP), .EVT_VALID(EVT_VALID),
   .EVT_CHANGED(EVT_CHANGED), .EVT_LEVELS(EVT_LEVELS));
